// File: tb_timer_channel_capture_compare.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_capture_compare;
   import tcc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   tcc_bus_t bus;
   tcc_link_t next_in, prev_in, link_out;
   logic [31:0] rdata, rv, v, e;
   logic [3:0] pin_lvl, pin_in, pin_out, pin_oe, irq_gr;
   logic tick_req, fast_req, sclr_req, sync_clr_in;
   logic phase_up, phase_dn, irq_ovf, irq_unf, adc_start;
   int n_fail, n_tests, n_a, n_adc, n_ovf, n_unf, m_st, c;
   int m_gr[4];
   logic [3:0] lv[6] = '{4'h1, 4'h0, 4'h4, 4'h0, 4'h1, 4'h5};
   logic [3:0] mk[6] = '{4'h3, 4'h2, 4'h8, 4'h4, 4'h3, 4'h8};
   int dv[6] = '{0, 1, 2, 3, 2, 2};
   int eg[6] = '{1, 1, 1, 1, 0, 2};
   int ex[6] = '{512, 128, 32, 8, 32, 64};

   tcc_channel #(.CHAN(0)) tcc_channel_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .bus(bus), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_clk(1'b0), .phase_up(phase_up), .phase_dn(phase_dn), .next_in(next_in),
      .prev_in(prev_in), .sync_clr_in(sync_clr_in), .link_out(link_out),
      .irq_gr(irq_gr), .irq_ovf(irq_ovf), .irq_unf(irq_unf), .adc_start(adc_start));
   tcc_nbr_model tcc_nbr_model_i (.pin_lvl(pin_lvl), .tick_req(tick_req),
      .fast_req(fast_req), .sclr_req(sclr_req), .pin_in(pin_in), .next_in(next_in),
      .prev_in(prev_in), .sync_clr_in(sync_clr_in));

   always #2.5 core_clk = ~core_clk;
   // Off the rising edge, so no race with the design
   always @(negedge core_clk) begin
      n_a += (irq_gr[0] === 1'b1);
      n_adc += (adc_start === 1'b1);
      n_ovf += (irq_ovf === 1'b1);
      n_unf += (irq_unf === 1'b1);
   end

   task tk(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tk
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task chkr(input string nm, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(nm, d, exp);
   endtask : chkr
   task cap(input logic [3:0] l, input logic [3:0] m, input bit bufac);
      logic [31:0] w;
      w = $urandom & 32'h0000_ffff;
      wr(4'h3, w);
      pin_lvl <= l;
      tk(8);
      for (int i = 0; i < 4; i++) begin
         if (m[i] && i == 0 && bufac) m_gr[2] = m_gr[0];
         if (m[i]) m_gr[i] = w;
      end
      m_st |= m;
      for (int i = 0; i < 4; i++) chkr("gr", 4'h4 + 4'(i), m_gr[i]);
      chkr("status", 4'h8, m_st);
   endtask : cap
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Tests need about 4100 cycles; 20000 allowed
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end

   initial begin
      bus = '0;
      pin_lvl = 4'h0;
      tick_req = 1'b0;
      fast_req = 1'b0;
      sclr_req = 1'b0;
      phase_up = 1'b0;
      phase_dn = 1'b0;
      m_gr = '{default: 32'h0000_ffff};
      void'($urandom(32'h4b08));
      tk(6);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) chkr("gr", 4'h4 + 4'(i), m_gr[i]);
      chkr("status", 4'h8, 32'h0000_0000);
      $display("reset test done");
      // A rise; B both edges of pin a; C fall, D rise of pin c
      wr(4'h1, 32'h0000_0327);
      wr(4'h2, 32'h0000_02e8);
      for (int i = 0; i < 6; i++) begin
         if (i == 4) begin
            wr(4'h0, 32'h0000_0200);
            wr(4'h2, 32'h0000_02e7);
         end
         cap(lv[i], mk[i], i >= 4);
      end
      wr(4'h0, 32'h0000_0000);
      wr(4'h1, 32'h0000_000a);
      wr(4'h2, 32'h0000_0000);
      for (int f = 1; f >= 0; f--) begin
         v = $urandom & 32'h0000_ffff;
         wr(4'h3, v);
         fast_req <= f[0];
         tick_req <= 1'b1;
         @(posedge core_clk);
         tick_req <= 1'b0;
         tk(4);
         if (f == 0) m_gr[0] = v;
         chkr("gr_a", 4'h4, m_gr[0]);
      end
      $display("capture tests done");
      for (int md = 1; md <= 6; md++) begin
         c = (md - 1) % 4 + 1;
         for (int i = 0; i < 4; i++)
            wr(4'h4 + 4'(i), (i == 0 || i == c - 1) ? 32'h0000_0009 : 32'h0000_ffff);
         wr(4'h1, 32'(md));
         wr(4'h3, 32'h0000_0000);
         wr(4'h8, 32'h0000_003f);
         n_a = 0;
         n_adc = 0;
         wr(4'h0, 32'h0000_0807 | 32'(c << 4));
         tk(60);
         // Converter enable kept so a late match still starts it
         wr(4'h0, 32'h0000_0800);
         tk(3);
         rd(4'h3, rv);
         chk("count_max", 32'(rv[15:0] <= 16'h0009), 32'h0000_0001);
         rd(4'h8, rv);
         chk("clr_flag", 32'(rv[c-1]), 32'h0000_0001);
         case (md)
            1: e = 0;
            2: e = 32'(n_a > 0);
            3: e = n_a % 2;
            4: e = 32'(n_a == 0);
            5: e = 1;
            default: e = 1 - n_a % 2;
         endcase
         chk("pin_a", {31'h0, pin_out[0]}, e);
         chk("adc", n_adc, n_a);
         chk("matches", 32'(n_a >= 4), 32'h0000_0001);
      end
      for (int i = 0; i < 4; i++) wr(4'h4 + 4'(i), 32'h0000_ffff);
      wr(4'h3, 32'h0000_0000);
      wr(4'h0, 32'h0000_0057);
      tk(20);
      sclr_req <= 1'b1;
      @(posedge core_clk);
      sclr_req <= 1'b0;
      wr(4'h0, 32'h0000_0000);
      rd(4'h3, rv);
      chk("sync_clr", 32'(rv[15:0] <= 16'h000c), 32'h0000_0001);
      $display("compare tests done");
      for (int i = 0; i < 6; i++) begin
         wr(4'h3, 32'h0000_0000);
         wr(4'h0, 32'h0000_0001 | 32'(eg[i] << 2) | 32'(dv[i] << 7));
         tk(512);
         wr(4'h0, 32'h0000_0000);
         rd(4'h3, rv);
         chk("rate", 32'(rv[15:0] + 3 >= ex[i] && rv[15:0] <= ex[i] + 3), 1);
      end
      $display("prescaler test done");
      for (int i = 0; i < 4; i++) wr(4'h4 + 4'(i), 32'h0000_1234);
      wr(4'h3, 32'h0000_ffff);
      wr(4'h8, 32'h0000_003f);
      n_ovf = 0;
      n_unf = 0;
      wr(4'h0, 32'h0000_1181);
      phase_up <= 1'b1;
      @(posedge core_clk);
      phase_up <= 1'b0;
      tk(2);
      phase_dn <= 1'b1;
      @(posedge core_clk);
      phase_dn <= 1'b0;
      tk(200);
      wr(4'h0, 32'h0000_0000);
      chkr("phase_cnt", 4'h3, 32'h0000_ffff);
      chkr("status", 4'h8, 32'h0000_0030);
      chk("ovf_irq", n_ovf, 1);
      chk("unf_irq", n_unf, 1);
      $display("phase test done");
      stop_test();
   end
endmodule : tb_timer_channel_capture_compare

bind tcc_channel tcc_chk tcc_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
   .pin_out(pin_out), .pin_oe(pin_oe), .link_out(link_out), .irq_gr(irq_gr),
   .irq_ovf(irq_ovf), .adc_start(adc_start));
`default_nettype wire

// File: tcc_channel.sv
`include "tcc_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01 - Counter advances on falling, rising or both edges of count clock.
// RULE_02 - Clearing selectable: off, after match on A, after match on B.
// RULE_03 - Clearing on C or D match only on channels 0, 3, 6, 9.
// RULE_04 - Synchronised channel clears when another synchronised channel clears.
// RULE_05 - Channels 0, 3, 6, 9 buffer pairs A/C and B/D independently.
// RULE_06 - A buffering register does not capture or compare itself.
// RULE_07 - Register A event requests converter start; not on channels 5, 6.
// RULE_08 - Compare pin: off, low, high, or initial level then set/clear/toggle.
// RULE_09 - Capture on rising, falling or both edges of selected pin.
// RULE_10 - Channels 0, 3, 6, 9 capture on channel n+1 count, not undivided.
// RULE_11 - Channels 1, 4, 7, 10 capture A on channel n-1 A event.
// RULE_12 - Channels 1, 4, 7, 10 capture B on channel n-1 C event.
// RULE_13 - Register B capture input is pin B or pin A.
// RULE_14 - Register D capture input is pin D or pin C.
// RULE_15 - Registers C, D exist only on channels 0, 3, 6, 9.
// RULE_16 - Each general register raises its own event interrupt.
// RULE_17 - Separate interrupt requests on overflow and underflow.
// RULE_18 - Phase counting mode ignores the count clock selection.
// RULE_19 - Software enables synchronous operation on at least two channels.
// RULE_20 - Count clock is peripheral clock divided by 1, 4, 16 or 64.
// RULE_21 - Capture copies counter; match when counter equals register.
// RULE_22 - Every event sets a sticky status flag cleared by software.
module tcc_channel
   import tcc_pkg::*;
#(
   parameter int CHAN = 0
) (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            sys_rst,
   // Register port
   input  wire tcc_pkg::tcc_bus_t bus,
   output logic [31:0]          rdata,
   // Pins
   input  wire logic [3:0]      pin_in,
   output logic [3:0]           pin_out,
   output logic [3:0]           pin_oe,
   input  wire logic            ext_clk,
   input  wire logic            phase_up,
   input  wire logic            phase_dn,
   // Neighbours
   input  wire tcc_pkg::tcc_link_t next_in,
   input  wire tcc_pkg::tcc_link_t prev_in,
   input  wire logic            sync_clr_in,
   output tcc_pkg::tcc_link_t   link_out,
   // Requests
   output logic [3:0]           irq_gr,
   output logic                 irq_ovf,
   output logic                 irq_unf,
   output logic                 adc_start
);
   import tcc_pkg::*;

   localparam bit HAS_CD   = (CHAN % 3) == 0;
   localparam bit HAS_PREV = (CHAN % 3) == 1;
   localparam bit HAS_ADC  = (CHAN != 5) && (CHAN != 6);

   function automatic logic hit(input logic [3:0] idx);
      return bus.addr == idx;
   endfunction : hit

   logic [15:0] ctrl_q;
   logic [19:0] io_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] gr_q [4];
   logic [`TCC_ST_W-1:0] st_q;
   logic [5:0]  pre_q;
   logic        srcf;
   logic [3:0]  prise;
   logic [3:0]  pfall;
   logic [3:0]  psync;
   logic        ext_lvl;
   logic        ext_rise;
   logic        ext_fall;
   logic [3:0]  match;
   logic [3:0]  cap_ev;
   logic [3:0]  is_cap;
   logic [3:0]  gr_ev;
   logic [3:0]  active;
   logic [3:0]  cap_rise;
   logic [3:0]  cap_fall;
   logic [3:0]  mode_wr;
   logic        tick;
   logic        up;
   logic        dn;
   logic        src;
   logic        ovf;
   logic        unf;
   logic        clr;
   logic        own_clr;
   tcc_clr_t    csel;

   // Pin synchronisers
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         tcc_sync3 u_sync (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .din      (pin_in[g]),
            .dout     (psync[g]),
            .rise     (prise[g]),
            .fall     (pfall[g])
         );
      end
   endgenerate

   tcc_sync3 u_ext (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .din      (ext_clk),
      .dout     (ext_lvl),
      .rise     (ext_rise),
      .fall     (ext_fall)
   );

   // RULE_20 prescaler
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pre_q <= 6'h00;
      end else begin
         pre_q <= pre_q + 6'h01;
      end
   end

   // Rise at period end, fall halfway: the count clock keeps the divided period
   always_comb begin
      case (ctrl_q[`TCC_CTRL_DIV_HI:`TCC_CTRL_DIV_LO])
         // Undivided clock: every cycle is an edge regardless of selection
         2'd0: begin
            src  = 1'b1;
            srcf = 1'b1;
         end
         2'd1: begin
            src  = pre_q[1:0] == `TCC_DIV4_LAST;
            srcf = pre_q[1:0] == `TCC_DIV4_HALF;
         end
         2'd2: begin
            src  = pre_q[3:0] == `TCC_DIV16_LAST;
            srcf = pre_q[3:0] == `TCC_DIV16_HALF;
         end
         default: begin
            src  = pre_q == `TCC_DIV64_LAST;
            srcf = pre_q == `TCC_DIV64_HALF;
         end
      endcase
   end

   always_comb begin
      logic r;
      logic f;
      r = ctrl_q[`TCC_CTRL_EXT] ? ext_rise : src;
      f = ctrl_q[`TCC_CTRL_EXT] ? ext_fall : srcf;
      // RULE_01 edge selection
      case (tcc_edge_t'(ctrl_q[`TCC_CTRL_EDGE_HI:`TCC_CTRL_EDGE_LO]))
         EDGE_FALL: tick = f;
         EDGE_RISE: tick = r;
         default:   tick = r || f;
      endcase
      // RULE_18 phase mode bypasses clock select
      if (ctrl_q[`TCC_CTRL_PHASE]) begin
         up = phase_up && !phase_dn && ctrl_q[`TCC_CTRL_RUN];
         dn = phase_dn && !phase_up && ctrl_q[`TCC_CTRL_RUN];
      end else begin
         up = tick && ctrl_q[`TCC_CTRL_RUN];
         dn = 1'b0;
      end
   end

   // RULE_05 RULE_06 RULE_15 which registers act
   always_comb begin
      active[0] = 1'b1;
      active[1] = 1'b1;
      active[2] = HAS_CD && !ctrl_q[`TCC_CTRL_BUF_AC];
      active[3] = HAS_CD && !ctrl_q[`TCC_CTRL_BUF_BD];
      cap_rise  = prise;
      cap_fall  = pfall;
      // RULE_13 B from pin A
      if (io_q[`TCC_IO_W+`TCC_IO_SEL]) begin
         cap_rise[1] = prise[0];
         cap_fall[1] = pfall[0];
      end
      // RULE_14 D from pin C
      if (io_q[3*`TCC_IO_W+`TCC_IO_SEL]) begin
         cap_rise[3] = prise[2];
         cap_fall[3] = pfall[2];
      end
   end

   generate
      for (g = 0; g < 4; g++) begin : g_gr
         logic prev_ev;
         // RULE_11 RULE_12 neighbour sources
         assign prev_ev = HAS_PREV && ((g == 0) ? prev_in.ev_a :
                                       (g == 1) ? prev_in.ev_c : 1'b0);
         assign mode_wr[g] = bus.wr && hit((g < 2) ? `TCC_REG_IOAB : `TCC_REG_IOCD);
         // RULE_21 equality compare
         assign match[g] = active[g] && !is_cap[g] && (cnt_q == gr_q[g]) && (up || dn);
         assign gr_ev[g] = match[g] || cap_ev[g];
         tcc_cmp_unit u_unit (
            .core_clk   (core_clk),
            .sys_rst    (sys_rst),
            .mode       (io_q[g*`TCC_IO_W +: 4]),
            .mode_wr    (mode_wr[g]),
            .active     (active[g]),
            .match      (match[g]),
            .pin_rise   (cap_rise[g]),
            .pin_fall   (cap_fall[g]),
            .cnt_tick   (HAS_CD && next_in.count_tick),
            .cnt_fast   (next_in.tick_is_fast),
            .prev_ev    (prev_ev),
            .cap_ev     (cap_ev[g]),
            .is_capture (is_cap[g]),
            .pin_out    (pin_out[g]),
            .pin_oe     (pin_oe[g])
         );
      end
   endgenerate

   // RULE_02 RULE_03 clear source
   always_comb begin
      csel = tcc_clr_t'(ctrl_q[`TCC_CTRL_CLR_HI:`TCC_CTRL_CLR_LO]);
      case (csel)
         CLR_A:   own_clr = match[0];
         CLR_B:   own_clr = match[1];
         CLR_C:   own_clr = HAS_CD && match[2];
         CLR_D:   own_clr = HAS_CD && match[3];
         default: own_clr = 1'b0;
      endcase
      // RULE_04 synchronised clear
      clr = own_clr || (csel == CLR_SYNC && ctrl_q[`TCC_CTRL_SYNC] && sync_clr_in);
      ovf = up && cnt_q == `TCC_CNT_MAX;
      unf = dn && cnt_q == `TCC_CNT_ZERO;
      cnt_d = cnt_q;
      if (clr) begin
         cnt_d = `TCC_CNT_ZERO;
      end else if (up) begin
         cnt_d = cnt_q + 16'h0001;
      end else if (dn) begin
         cnt_d = cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= `TCC_CNT_ZERO;
      end else if (bus.wr && hit(`TCC_REG_COUNT)) begin
         cnt_q <= bus.wdata[15:0];
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Control registers; C/D fields dropped where absent
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= 16'h0000;
         io_q   <= 20'h0_0000;
      end else if (bus.wr) begin
         if (hit(`TCC_REG_CTRL)) begin
            ctrl_q <= bus.wdata[15:0];
            if (!HAS_CD) begin
               ctrl_q[`TCC_CTRL_BUF_BD:`TCC_CTRL_BUF_AC] <= 2'b00;
            end
         end
         if (hit(`TCC_REG_IOAB)) begin
            io_q[9:0] <= bus.wdata[9:0];
         end
         // RULE_15 absent registers ignore writes
         if (hit(`TCC_REG_IOCD) && HAS_CD) begin
            io_q[19:10] <= bus.wdata[9:0];
         end
      end
   end

   // RULE_21 capture copy, RULE_05 buffer transfer at match (A/B) or at capture (C/D)
   generate
      for (g = 0; g < 4; g++) begin : g_store
         // Other register of the buffer pair, always in range
         localparam int PAIR = (g < 2) ? g + 2 : g - 2;
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               gr_q[g] <= 16'hffff;
            end else if (bus.wr && hit(`TCC_REG_GRA + 4'(g)) && (g < 2 || HAS_CD)) begin
               gr_q[g] <= bus.wdata[15:0];
            end else if (cap_ev[g]) begin
               gr_q[g] <= cnt_q;
            end else if (g < 2 && HAS_CD && match[g] &&
                         ctrl_q[`TCC_CTRL_BUF_AC + g]) begin
               gr_q[g] <= gr_q[PAIR];
            end else if (g >= 2 && cap_ev[PAIR] && ctrl_q[`TCC_CTRL_BUF_AC + PAIR]) begin
               gr_q[g] <= gr_q[PAIR];
            end
         end
      end
   endgenerate

   // RULE_22 sticky flags, set wins over clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= 6'h00;
      end else begin
         if (bus.wr && hit(`TCC_REG_STATUS)) begin
            st_q <= (st_q & ~bus.wdata[5:0]) | {unf, ovf, gr_ev};
         end else begin
            st_q <= st_q | {unf, ovf, gr_ev};
         end
      end
   end

   // RULE_16 RULE_17 RULE_07 request pulses
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_gr    <= 4'h0;
         irq_ovf   <= 1'b0;
         irq_unf   <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         irq_gr    <= gr_ev;
         irq_ovf   <= ovf;
         irq_unf   <= unf;
         adc_start <= HAS_ADC && ctrl_q[`TCC_CTRL_ADC] && gr_ev[0];
      end
   end

   always_comb begin
      // Own clears only, so linked channels form no combinational loop
      link_out.sync_clr     = ctrl_q[`TCC_CTRL_SYNC] && own_clr;
      link_out.count_tick   = up || dn;
      link_out.tick_is_fast = !ctrl_q[`TCC_CTRL_EXT] && !ctrl_q[`TCC_CTRL_PHASE] &&
                              ctrl_q[`TCC_CTRL_DIV_HI:`TCC_CTRL_DIV_LO] == 2'd0;
      link_out.ev_a         = gr_ev[0];
      link_out.ev_c         = gr_ev[2];
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata <= `TCC_ZERO32;
      end else if (bus.rd) begin
         case (bus.addr)
            `TCC_REG_CTRL:   rdata <= {16'h0000, ctrl_q};
            `TCC_REG_IOAB:   rdata <= {22'h00_0000, io_q[9:0]};
            `TCC_REG_IOCD:   rdata <= {22'h00_0000, io_q[19:10]};
            `TCC_REG_COUNT:  rdata <= {16'h0000, cnt_q};
            `TCC_REG_GRA:    rdata <= {16'h0000, gr_q[0]};
            `TCC_REG_GRB:    rdata <= {16'h0000, gr_q[1]};
            `TCC_REG_GRC:    rdata <= HAS_CD ? {16'h0000, gr_q[2]} : `TCC_ZERO32;
            `TCC_REG_GRD:    rdata <= HAS_CD ? {16'h0000, gr_q[3]} : `TCC_ZERO32;
            `TCC_REG_STATUS: rdata <= {26'h000_0000, st_q};
            `TCC_REG_PHASE:  rdata <= {28'h000_0000, psync};
            default:         rdata <= `TCC_ZERO32;
         endcase
      end else begin
         rdata <= `TCC_ZERO32;
      end
   end
   // External level unused; only its edges count
   logic unused_ok;
   assign unused_ok = ext_lvl;
endmodule : tcc_channel
`default_nettype wire

// File: tcc_chk_props.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_chk
   import tcc_pkg::*;
(
   // Clock and reset
   input wire logic                core_clk,
   input wire logic                sys_rst,
   // Watched ports
   input wire tcc_pkg::tcc_bus_t   bus,
   input wire logic [3:0]          pin_out,
   input wire logic [3:0]          pin_oe,
   input wire tcc_pkg::tcc_link_t  link_out,
   input wire logic [3:0]          irq_gr,
   input wire logic                irq_ovf,
   input wire logic                adc_start
);
   import tcc_pkg::*;
   logic [13:0] ctrl_q;
   logic [3:0]  mode_a_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Setup is not on the ports, so mirror the writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q   <= 14'h0000;
         mode_a_q <= 4'h0;
      end else if (bus.wr) begin
         if (bus.addr == 4'h0) ctrl_q <= bus.wdata[13:0];
         if (bus.addr == 4'h1) mode_a_q <= bus.wdata[3:0];
      end
   end
   a_adc_on_a: assert property (adc_start |-> irq_gr[0] && $past(ctrl_q[11]))
      else $error("converter start without register A event");
   a_adc_each_a: assert property (
      irq_gr[0] && ctrl_q[11] && $past(ctrl_q[11]) |-> adc_start)
      else $error("register A event gave no converter start");
   a_ev_a_irq: assert property (link_out.ev_a |=> irq_gr[0])
      else $error("register A event without request");
   a_ev_c_irq: assert property (link_out.ev_c |=> irq_gr[2])
      else $error("register C event without request");
   a_irq_a_cause: assert property (irq_gr[0] |-> $past(link_out.ev_a))
      else $error("register A request without event");
   a_sync_src: assert property (link_out.sync_clr |-> ctrl_q[1])
      else $error("sync clear sent while not synchronised");
   a_oe_by_mode: assert property (
      pin_oe[0] == (mode_a_q inside {[4'h1:4'h6]}))
      else $error("pin a enable does not follow mode");
   a_fixed_low: assert property ((mode_a_q == 4'h1) [*3] |-> !pin_out[0])
      else $error("pin a not low in fixed low mode");
   a_fixed_high: assert property ((mode_a_q == 4'h5) [*3] |-> pin_out[0])
      else $error("pin a not high in fixed high mode");
   a_ovf_single: assert property (irq_ovf |=> !irq_ovf)
      else $error("overflow request longer than one cycle");
endmodule : tcc_chk
`default_nettype wire

// File: tcc_cmp_unit.sv
`timescale 1ns/1ps
`default_nettype none
// One general register's pin logic: compare output and capture edge detect
module tcc_cmp_unit
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Setup
   input  wire logic [3:0]  mode,
   input  wire logic        mode_wr,
   input  wire logic        active,
   // Events
   input  wire logic        match,
   input  wire logic        pin_rise,
   input  wire logic        pin_fall,
   input  wire logic        cnt_tick,
   input  wire logic        cnt_fast,
   input  wire logic        prev_ev,
   // Results
   output var  logic        cap_ev,
   output var  logic        is_capture,
   output var  logic        pin_out,
   output var  logic        pin_oe
);
   import tcc_pkg::*;
   tcc_io_t m;
   logic    reload_q;
   always_comb begin
      m = tcc_io_t'(mode);
      is_capture = active && (m >= IO_CAP_RISE);
      case (m)
         // RULE_09 capture edges
         IO_CAP_RISE: cap_ev = active && pin_rise;
         IO_CAP_FALL: cap_ev = active && pin_fall;
         IO_CAP_BOTH: cap_ev = active && (pin_rise || pin_fall);
         // RULE_10 neighbour count capture
         IO_CAP_CNT:  cap_ev = active && cnt_tick && !cnt_fast;
         // RULE_11 previous channel event
         IO_CAP_PREV: cap_ev = active && prev_ev;
         default:     cap_ev = 1'b0;
      endcase
      pin_oe = active && (m != IO_OFF) && (m < IO_CAP_RISE);
   end
   // Mode takes the write on that edge, so reload from it one cycle later
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reload_q <= 1'b0;
      end else begin
         reload_q <= mode_wr;
      end
   end
   // RULE_08 compare pin drive
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_out <= 1'b0;
      end else if (reload_q) begin
         pin_out <= (m == IO_HIGH_CLR) || (m == IO_HIGH) || (m == IO_HIGH_TGL);
      end else if (active && match) begin
         case (m)
            IO_LOW_SET:  pin_out <= 1'b1;
            IO_HIGH_CLR: pin_out <= 1'b0;
            IO_LOW_TGL,
            IO_HIGH_TGL: pin_out <= !pin_out;
            default:     pin_out <= pin_out;
         endcase
      end
   end
endmodule : tcc_cmp_unit
`default_nettype wire

// File: tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// Register indices on the plain port
`define TCC_REG_CTRL     4'h0
`define TCC_REG_IOAB     4'h1
`define TCC_REG_IOCD     4'h2
`define TCC_REG_COUNT    4'h3
`define TCC_REG_GRA      4'h4
`define TCC_REG_GRB      4'h5
`define TCC_REG_GRC      4'h6
`define TCC_REG_GRD      4'h7
`define TCC_REG_STATUS   4'h8
`define TCC_REG_PHASE    4'h9
// Control fields
`define TCC_CTRL_RUN     0
`define TCC_CTRL_SYNC    1
`define TCC_CTRL_EDGE_LO 2
`define TCC_CTRL_EDGE_HI 3
`define TCC_CTRL_CLR_LO  4
`define TCC_CTRL_CLR_HI  6
`define TCC_CTRL_DIV_LO  7
`define TCC_CTRL_DIV_HI  8
`define TCC_CTRL_BUF_AC  9
`define TCC_CTRL_BUF_BD  10
`define TCC_CTRL_ADC     11
`define TCC_CTRL_PHASE   12
`define TCC_CTRL_EXT     13
// Per-register io field: mode in 4 bits, input select in bit 4
`define TCC_IO_W         5
`define TCC_IO_SEL       4
`define TCC_IO_MODE_HI   3
// Status bits: a,b,c,d,ovf,unf
`define TCC_ST_OVF       4
`define TCC_ST_UNF       5
`define TCC_ST_W         6
// Prescaler
`define TCC_DIV4_LAST    6'h03
`define TCC_DIV16_LAST   6'h0f
`define TCC_DIV64_LAST   6'h3f
`define TCC_DIV4_HALF    6'h01
`define TCC_DIV16_HALF   6'h07
`define TCC_DIV64_HALF   6'h1f
`define TCC_CNT_MAX      16'hffff
`define TCC_CNT_ZERO     16'h0000
`define TCC_ZERO32       32'h0000_0000
`endif

// File: tcc_nbr_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pins and neighbour channels, steered by the bench
module tcc_nbr_model
   import tcc_pkg::*;
(
   // Requests from the bench
   input wire logic [3:0]          pin_lvl,
   input wire logic                tick_req,
   input wire logic                fast_req,
   input wire logic                sclr_req,
   // Towards the channel
   output var logic [3:0]          pin_in,
   output var tcc_pkg::tcc_link_t  next_in,
   output var tcc_pkg::tcc_link_t  prev_in,
   output var logic                sync_clr_in
);
   import tcc_pkg::*;
   assign pin_in = pin_lvl;
   assign next_in = '{1'b0, tick_req, fast_req, 1'b0, 1'b0};
   // Channel zero has no lower neighbour
   assign prev_in = '0;
   assign sync_clr_in = sclr_req;
endmodule : tcc_nbr_model
`default_nettype wire

// File: tcc_pkg.sv
package tcc_pkg;
   typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_RSV} tcc_edge_t;
   typedef enum logic [2:0] {CLR_NONE, CLR_A, CLR_B, CLR_C, CLR_D, CLR_SYNC} tcc_clr_t;
   // io mode codes, 4 bits
   typedef enum logic [3:0] {
      IO_OFF, IO_LOW, IO_LOW_SET, IO_LOW_TGL, IO_HIGH_CLR, IO_HIGH, IO_HIGH_TGL,
      IO_CAP_RISE, IO_CAP_FALL, IO_CAP_BOTH, IO_CAP_CNT, IO_CAP_PREV
   } tcc_io_t;
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } tcc_bus_t;
   // Neighbour channel links
   typedef struct packed {
      logic sync_clr;
      logic count_tick;
      logic tick_is_fast;
      logic ev_a;
      logic ev_c;
   } tcc_link_t;
endpackage : tcc_pkg

// File: tcc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser, change accepted when stages two and three agree
module tcc_sync3 (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Data
   input  wire logic din,
   output var  logic dout,
   output var  logic rise,
   output var  logic fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout <= s3_q;
         end
      end
   end
   always_comb begin
      rise = (s2_q == s3_q) && s3_q && !dout;
      fall = (s2_q == s3_q) && !s3_q && dout;
   end
endmodule : tcc_sync3
`default_nettype wire
